// >>> tpac_pkg.sv
`default_nettype none
// ----------------------------------------------------------------------------
// Touch panel and converter control constants
// ----------------------------------------------------------------------------
package tpac_pkg;

    // ------------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------------
    localparam logic [3:0]  OFS_PANEL       = 4'h9;
    localparam logic [3:0]  OFS_CTRL        = 4'hA;
    localparam logic [3:0]  OFS_RESULT      = 4'hB;
    localparam logic [3:0]  OFS_IDENT       = 4'hC;
    localparam logic [3:0]  OFS_TEST        = 4'hD;

    // ------------------------------------------------------------------------
    // Panel control fields
    // ------------------------------------------------------------------------
    localparam int          PNL_XM_POW      = 0;
    localparam int          PNL_XP_POW      = 1;
    localparam int          PNL_YM_POW      = 2;
    localparam int          PNL_YP_POW      = 3;
    localparam int          PNL_XM_GND      = 4;
    localparam int          PNL_XP_GND      = 5;
    localparam int          PNL_YM_GND      = 6;
    localparam int          PNL_YP_GND      = 7;
    localparam int          PNL_MODE_LSB    = 8;
    localparam int          PNL_MODE_MSB    = 9;
    localparam int          PNL_BIAS        = 11;
    localparam int          PNL_XP_LOW      = 12;
    localparam int          PNL_XM_LOW      = 13;
    localparam logic [15:0] PNL_WMASK       = 16'h0BFF;
    localparam logic [15:0] PNL_RESET       = 16'h0000;

    // ------------------------------------------------------------------------
    // Converter control fields
    // ------------------------------------------------------------------------
    localparam int          CTL_SYNC        = 0;
    localparam int          CTL_BYP_CON     = 1;
    localparam int          CTL_SEL_LSB     = 2;
    localparam int          CTL_SEL_MSB     = 4;
    localparam int          CTL_EXT_REF     = 5;
    localparam int          CTL_START       = 7;
    localparam int          CTL_ENABLE      = 15;
    localparam logic [15:0] CTL_WMASK       = 16'h80BF;
    localparam logic [15:0] CTL_RESET       = 16'h0000;

    // ------------------------------------------------------------------------
    // Result, identification and test-mode fields
    // ------------------------------------------------------------------------
    localparam int          RES_WIDTH       = 10;
    localparam int          RES_LSB         = 5;
    localparam int          RES_MSB         = 14;
    localparam int          RES_VALID       = 15;
    localparam int          ID_REV_LSB      = 0;
    localparam int          ID_PART_LSB     = 6;
    localparam int          ID_MAKER_LSB    = 12;
    localparam int          TST_AUDIO       = 0;
    localparam int          TST_TELECOM     = 1;
    localparam int          TST_PROD_LSB    = 2;
    localparam int          TST_PROD_MSB    = 5;
    localparam logic [15:0] TST_WMASK       = 16'h003F;
    localparam logic [15:0] TST_RESET       = 16'h0000;

    // ------------------------------------------------------------------------
    // Conversion timing
    // ------------------------------------------------------------------------
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          SAMPLE_TIME_NS  = 100;
    localparam int          BIT_TIME_NS     = 60; // Outlasts comparator sync
    localparam int          SAMPLE_CYCLES   = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1)
                                              / CLK_PERIOD_NS;
    localparam int          BIT_CYCLES      = (BIT_TIME_NS + CLK_PERIOD_NS - 1)
                                              / CLK_PERIOD_NS;

endpackage
`default_nettype wire

// >>> tpac_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Three-stage pin synchroniser, output moves once stages two and three agree
// ----------------------------------------------------------------------------
module tpac_pin_sync (
    // Clock and reset
    input  wire logic mclk_in,
    input  wire logic rst_b_in,
    // Pin and clean level
    input  wire logic pin_in,
    output logic      level_out
);

    logic stage1_q;
    logic stage2_q;
    logic stage3_q;
    logic level_q;

    // Stage one feeds stage two only, to keep metastability contained
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
            stage3_q <= 1'b0;
            level_q  <= 1'b0;
        end else begin
            stage1_q <= pin_in;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
            if (stage2_q == stage3_q) begin
                level_q <= stage3_q;
            end
        end
    end

    assign level_out = level_q;

endmodule // tpac_pin_sync
`default_nettype wire

// >>> tpac_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Ground bits 5-7 ground x+, y-, y+
// - Mode bits 8-9: interrupt, pressure, position
// - Bit 11 switches panel bias on
// - Bit 12 reads inverted x+ pin
// - Bit 13 reads inverted x- pin
// - Control bit 0 enables synchronised conversion
// - Control bit 1 routes reference to bypass
// - Bits 2-4 select plate or external input
// - Control bit 5 selects external reference
// - Conversion starts only on start rising
// - Control bit 15 powers the converter
// - Result bits 5-14 hold ten-bit result
// - Result bit 15 valid once stored
// - Identification word returns fixed codes
// - Test bit 0 audio analogue test
// - Test bit 1 telecom analogue test
// - Test bits 2-5 production test select
// - Test bits written only with test pin
// - Panel bit 4 grounds x- plate
// - Panel bits 0-3 power the plates
module tpac_regs #(
    parameter logic [5:0] REVISION_CODE = 6'h15, // Arbitrary value
    parameter logic [5:0] PART_CODE     = 6'h2A, // Arbitrary value
    parameter logic [3:0] MAKER_CODE    = 4'hA   // Arbitrary value
) (
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rst_b_in,
    // Register port
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_write_in,
    input  wire logic        reg_read_in,
    output logic      [15:0] reg_rdata_out,
    // Panel pins and test pin
    input  wire logic        x_plus_plate_pin_in,
    input  wire logic        x_minus_plate_pin_in,
    input  wire logic        test_pin_in,
    // Converter analogue side
    input  wire logic        sync_trigger_in,
    input  wire logic        comparator_high_in,
    // Panel switches
    output logic             x_minus_plate_power_out,
    output logic             x_plus_plate_power_out,
    output logic             y_minus_plate_power_out,
    output logic             y_plus_plate_power_out,
    output logic             x_minus_plate_ground_out,
    output logic             x_plus_plate_ground_out,
    output logic             y_minus_plate_ground_out,
    output logic             y_plus_plate_ground_out,
    output logic             interrupt_mode_out,
    output logic             pressure_mode_out,
    output logic             position_mode_out,
    output logic             panel_bias_enable_out,
    // Converter controls
    output logic             converter_sync_enable_out,
    output logic             reference_bypass_connect_out,
    output logic             external_reference_enable_out,
    output logic             converter_enable_out,
    output logic      [7:0]  input_select_out,
    output logic      [9:0]  sar_trial_code_out,
    output logic             track_hold_out,
    output logic             conversion_busy_out,
    // Test modes
    output logic             audio_analogue_test_out,
    output logic             telecom_analogue_test_out,
    output logic      [3:0]  production_test_select_out
);

    // ------------------------------------------------------------------------
    // Types and local constants
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT_SYNC, ST_SAMPLE, ST_CONVERT} tpac_state_e;

    localparam logic [7:0] SAMPLE_LOAD = 8'(tpac_pkg::SAMPLE_CYCLES - 1);
    localparam logic [7:0] BIT_LOAD    = 8'(tpac_pkg::BIT_CYCLES - 1);
    localparam logic [9:0] MSB_TRIAL   = 10'h200;
    localparam logic [3:0] MSB_INDEX   = 4'h9;

    logic [15:0]  panel_q;
    logic [15:0]  ctrl_q;
    logic [15:0]  test_q;
    logic [15:0]  rdata_q;
    logic [9:0]   result_q;
    logic         valid_q;
    tpac_state_e  state_q;
    tpac_state_e  state_d;
    logic [7:0]   cnt_q;
    logic [7:0]   cnt_d;
    logic [3:0]   idx_q;
    logic [3:0]   idx_d;
    logic [9:0]   trial_q;
    logic [9:0]   trial_d;
    logic         sync_prev_q;

    logic         x_plus_level;
    logic         x_minus_level;
    logic         test_level;
    logic         sync_level;
    logic         comp_level;

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    tpac_pin_sync u_sync_xp (
        .mclk_in   (mclk_in),
        .rst_b_in  (rst_b_in),
        .pin_in    (x_plus_plate_pin_in),
        .level_out (x_plus_level)
    );

    tpac_pin_sync u_sync_xm (
        .mclk_in   (mclk_in),
        .rst_b_in  (rst_b_in),
        .pin_in    (x_minus_plate_pin_in),
        .level_out (x_minus_level)
    );

    tpac_pin_sync u_sync_test (
        .mclk_in   (mclk_in),
        .rst_b_in  (rst_b_in),
        .pin_in    (test_pin_in),
        .level_out (test_level)
    );

    tpac_pin_sync u_sync_trig (
        .mclk_in   (mclk_in),
        .rst_b_in  (rst_b_in),
        .pin_in    (sync_trigger_in),
        .level_out (sync_level)
    );

    tpac_pin_sync u_sync_comp (
        .mclk_in   (mclk_in),
        .rst_b_in  (rst_b_in),
        .pin_in    (comparator_high_in),
        .level_out (comp_level)
    );

    // ------------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------------
    wire        wr_panel = reg_write_in && (reg_addr_in == tpac_pkg::OFS_PANEL);
    wire        wr_ctrl  = reg_write_in && (reg_addr_in == tpac_pkg::OFS_CTRL);
    wire        wr_test  = reg_write_in && (reg_addr_in == tpac_pkg::OFS_TEST)
                           && test_level;
    // Start on a written rise of the start bit
    wire        start_edge = wr_ctrl && reg_wdata_in[tpac_pkg::CTL_START]
                             && !ctrl_q[tpac_pkg::CTL_START];
    wire        conv_on    = ctrl_q[tpac_pkg::CTL_ENABLE];
    wire        sync_mode  = ctrl_q[tpac_pkg::CTL_SYNC];
    wire        sync_rise  = sync_level && !sync_prev_q;

    // Masks drop read-only and unlisted bits
    wire [15:0] panel_wr_d = reg_wdata_in & tpac_pkg::PNL_WMASK;
    wire [15:0] ctrl_wr_d  = reg_wdata_in & tpac_pkg::CTL_WMASK;
    wire [15:0] test_wr_d  = reg_wdata_in & tpac_pkg::TST_WMASK;

    // ------------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            panel_q <= tpac_pkg::PNL_RESET;
            ctrl_q  <= tpac_pkg::CTL_RESET;
            test_q  <= tpac_pkg::TST_RESET;
        end else begin
            if (wr_panel) begin
                panel_q <= panel_wr_d;
            end
            if (wr_ctrl) begin
                ctrl_q <= ctrl_wr_d;
            end
            if (wr_test) begin
                test_q <= test_wr_d;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Read mux, unmapped offsets read zero
    // ------------------------------------------------------------------------
    wire [15:0] panel_rd = panel_q
                           | (16'(!x_plus_level) << tpac_pkg::PNL_XP_LOW)
                           | (16'(!x_minus_level) << tpac_pkg::PNL_XM_LOW);
    wire [15:0] result_rd = (16'(valid_q) << tpac_pkg::RES_VALID)
                            | (16'(result_q) << tpac_pkg::RES_LSB);
    wire [15:0] ident_rd  = (16'(MAKER_CODE) << tpac_pkg::ID_MAKER_LSB)
                            | (16'(PART_CODE) << tpac_pkg::ID_PART_LSB)
                            | (16'(REVISION_CODE) << tpac_pkg::ID_REV_LSB);
    wire [15:0] rd_mux    = (reg_addr_in == tpac_pkg::OFS_PANEL)  ? panel_rd  :
                            (reg_addr_in == tpac_pkg::OFS_CTRL)   ? ctrl_q    :
                            (reg_addr_in == tpac_pkg::OFS_RESULT) ? result_rd :
                            (reg_addr_in == tpac_pkg::OFS_IDENT)  ? ident_rd  :
                            (reg_addr_in == tpac_pkg::OFS_TEST)   ? test_q    :
                            16'h0000;

    // Read data held until the next read strobe
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_q <= 16'h0000;
        end else if (reg_read_in) begin
            rdata_q <= rd_mux;
        end
    end

    // ------------------------------------------------------------------------
    // Conversion sequencer, next state
    // ------------------------------------------------------------------------
    // One bit per BIT_CYCLES, MSB first
    // Slot outlasts the four-edge comparator sync
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        idx_d   = idx_q;
        trial_d = trial_q;
        case (state_q)
            ST_IDLE: begin
                if (start_edge && conv_on) begin
                    state_d = sync_mode ? ST_WAIT_SYNC : ST_SAMPLE;
                    cnt_d   = SAMPLE_LOAD;
                end
            end
            ST_WAIT_SYNC: begin
                if (sync_rise) begin
                    state_d = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (cnt_q == 8'h00) begin
                    state_d = ST_CONVERT;
                    cnt_d   = BIT_LOAD;
                    idx_d   = MSB_INDEX;
                    trial_d = MSB_TRIAL;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            ST_CONVERT: begin
                if (cnt_q == 8'h00) begin
                    if (!comp_level) begin
                        trial_d = trial_q & ~(10'h001 << idx_q);
                    end
                    if (idx_q == 4'h0) begin
                        state_d = ST_IDLE;
                    end else begin
                        idx_d   = idx_q - 4'h1;
                        trial_d = trial_d | (10'h001 << (idx_q - 4'h1));
                        cnt_d   = BIT_LOAD;
                    end
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (!conv_on) begin
            state_d = ST_IDLE;
        end
    end

    wire conv_done = (state_q == ST_CONVERT) && (cnt_q == 8'h00)
                     && (idx_q == 4'h0) && conv_on;
    wire conv_go   = (state_q == ST_IDLE) && start_edge && conv_on;

    // ------------------------------------------------------------------------
    // Conversion sequencer, registers
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q     <= ST_IDLE;
            cnt_q       <= 8'h00;
            idx_q       <= 4'h0;
            trial_q     <= 10'h000;
            sync_prev_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            idx_q       <= idx_d;
            trial_q     <= trial_d;
            sync_prev_q <= sync_level;
        end
    end

    // Result and valid; valid drops at launch
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            result_q <= 10'h000;
            valid_q  <= 1'b0;
        end else if (conv_done) begin
            result_q <= trial_d;
            valid_q  <= 1'b1;
        end else if (conv_go) begin
            valid_q  <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Panel outputs
    // ------------------------------------------------------------------------
    assign x_minus_plate_power_out  = panel_q[tpac_pkg::PNL_XM_POW];
    assign x_plus_plate_power_out   = panel_q[tpac_pkg::PNL_XP_POW];
    assign y_minus_plate_power_out  = panel_q[tpac_pkg::PNL_YM_POW];
    assign y_plus_plate_power_out   = panel_q[tpac_pkg::PNL_YP_POW];
    assign x_minus_plate_ground_out = panel_q[tpac_pkg::PNL_XM_GND];
    assign x_plus_plate_ground_out  = panel_q[tpac_pkg::PNL_XP_GND];
    assign y_minus_plate_ground_out = panel_q[tpac_pkg::PNL_YM_GND];
    assign y_plus_plate_ground_out  = panel_q[tpac_pkg::PNL_YP_GND];
    assign panel_bias_enable_out    = panel_q[tpac_pkg::PNL_BIAS];

    // Upper mode bit alone picks position measurement
    wire [1:0] mode_field   = panel_q[tpac_pkg::PNL_MODE_MSB:tpac_pkg::PNL_MODE_LSB];
    assign interrupt_mode_out = (mode_field == 2'h0);
    assign pressure_mode_out  = (mode_field == 2'h1);
    assign position_mode_out  = mode_field[1];

    // ------------------------------------------------------------------------
    // Converter and test-mode outputs
    // ------------------------------------------------------------------------
    assign converter_sync_enable_out     = ctrl_q[tpac_pkg::CTL_SYNC];
    assign reference_bypass_connect_out  = ctrl_q[tpac_pkg::CTL_BYP_CON];
    assign external_reference_enable_out = ctrl_q[tpac_pkg::CTL_EXT_REF];
    assign converter_enable_out          = conv_on;

    // One-hot select: 0-3 plates, 4-7 external inputs zero to three
    wire [2:0] sel_field = ctrl_q[tpac_pkg::CTL_SEL_MSB:tpac_pkg::CTL_SEL_LSB];
    assign input_select_out    = 8'h01 << sel_field;
    assign sar_trial_code_out  = trial_q;
    assign track_hold_out      = (state_q == ST_SAMPLE);
    assign conversion_busy_out = (state_q != ST_IDLE);

    assign audio_analogue_test_out    = test_q[tpac_pkg::TST_AUDIO];
    assign telecom_analogue_test_out  = test_q[tpac_pkg::TST_TELECOM];
    assign production_test_select_out =
        test_q[tpac_pkg::TST_PROD_MSB:tpac_pkg::TST_PROD_LSB];

    assign reg_rdata_out = rdata_q;

endmodule // tpac_regs
`default_nettype wire

// >>> tpac_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// --------
// Controller side of the register port
// --------
module tpac_ctrl_model (
    // Clock and register port
    input  wire logic        mclk_in,
    input  wire logic [15:0] rdata_in,
    output var  logic [3:0]  addr_out,
    output var  logic [15:0] wdata_out,
    output var  logic        wr_out,
    output var  logic        rd_out,
    // Test pin
    output var  logic        tpin_out
);
    // Idle port, test pin high
    initial begin
        {addr_out, wdata_out, wr_out, rd_out} = '0;
        tpin_out = 1'b1;
    end
    // Whole-word write, strobe for one cycle
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        {addr_out, wdata_out, wr_out} <= {a, d, 1'b1};
        @(posedge mclk_in);
        {wdata_out, wr_out} <= {~d, 1'b0};
    endtask
    // Data taken while it stands
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk_in);
        {addr_out, rd_out} <= {a, 1'b1};
        @(posedge mclk_in);
        rd_out <= 1'b0;
        @(posedge mclk_in);
        d = rdata_in;
    endtask
endmodule // tpac_ctrl_model
`default_nettype wire

// >>> tpac_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// --------
// Port checker
// --------
module tpac_regs_monitor (
    // Clock, reset and register port
    input wire logic        mclk_in,
    input wire logic        rst_b_in,
    input wire logic [3:0]  reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic        reg_write_in,
    input wire logic        reg_read_in,
    input wire logic [15:0] reg_rdata_out,
    // Outputs under watch
    input wire logic        y_plus_plate_ground_out,
    input wire logic        x_minus_plate_power_out,
    input wire logic        position_mode_out,
    input wire logic [7:0]  input_select_out,
    input wire logic        conversion_busy_out,
    input wire logic        converter_enable_out,
    input wire logic        converter_sync_enable_out,
    input wire logic [3:0]  production_test_select_out
);
    wire logic pw = reg_write_in && reg_addr_in == 4'h9;
    wire logic cw = reg_write_in && reg_addr_in == 4'hA;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    chk_plate_gnd: assert property (
        pw |=> y_plus_plate_ground_out == $past(reg_wdata_in[7])) else $error("ground bit");
    chk_plate_pow: assert property (
        pw |=> x_minus_plate_power_out == $past(reg_wdata_in[0])) else $error("power bit");
    chk_mode_pos: assert property (
        pw |=> position_mode_out == $past(reg_wdata_in[9])) else $error("position mode");
    chk_sel_code: assert property (
        cw |=> input_select_out == 8'h01 << $past(reg_wdata_in[4:2])) else $error("select");
    chk_sync_bit: assert property (
        cw |=> converter_sync_enable_out == $past(reg_wdata_in[0])) else $error("sync bit");
    chk_start_cause: assert property (
        $rose(conversion_busy_out) |-> $past(cw && reg_wdata_in[7] && converter_enable_out))
        else $error("start cause");
    chk_busy_len: assert property (
        $rose(conversion_busy_out) && !converter_sync_enable_out
        |-> ##69 conversion_busy_out ##1 !conversion_busy_out) else $error("busy length");
    chk_rd_ident: assert property (
        reg_read_in && reg_addr_in == 4'hC |=> reg_rdata_out == 16'hAA95) else $error("ident");
    chk_rd_unmap: assert property (
        reg_read_in && (reg_addr_in < 4'h9 || reg_addr_in > 4'hD) |=> reg_rdata_out == 16'h0000)
        else $error("unmapped");
    chk_test_gate: assert property (
        $changed(production_test_select_out) |-> $past(reg_write_in && reg_addr_in == 4'hD))
        else $error("test select");
    // Main scenarios
    cov_start: cover property ($rose(conversion_busy_out));
    cov_done: cover property ($fell(conversion_busy_out));
    cov_test: cover property (reg_write_in && reg_addr_in == 4'hD);
endmodule // tpac_regs_monitor
bind tpac_regs tpac_regs_monitor u_mon (.*);
`default_nettype wire

// >>> touch_panel_adc_control_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
    $display("ERROR %0t: got %h want %h", $time, (a), (b)); end end
// --------
// Register block bench
// --------
module touch_panel_adc_control_regs_bench;
    localparam logic [9:0]  TGT = 10'h2C5;
    localparam logic [15:0] RES = {1'b1, TGT, 5'h00};
    logic mclk_in, rst_b_in, reg_write_in, reg_read_in, test_pin_in, sync_trigger_in;
    logic x_plus_plate_pin_in, x_minus_plate_pin_in, comparator_high_in, track_hold_out;
    logic x_minus_plate_power_out, x_plus_plate_power_out, y_minus_plate_power_out;
    logic y_plus_plate_power_out, x_minus_plate_ground_out, x_plus_plate_ground_out;
    logic y_minus_plate_ground_out, y_plus_plate_ground_out, interrupt_mode_out;
    logic pressure_mode_out, position_mode_out, panel_bias_enable_out;
    logic converter_sync_enable_out, reference_bypass_connect_out, converter_enable_out;
    logic external_reference_enable_out, conversion_busy_out;
    logic audio_analogue_test_out, telecom_analogue_test_out;
    logic [3:0]  reg_addr_in, production_test_select_out;
    logic [7:0]  input_select_out;
    logic [9:0]  sar_trial_code_out;
    logic [15:0] reg_wdata_in, reg_rdata_out, rdv;
    int          failures = 0, cmp_count = 0, cyc = 0;
    // Output snapshot, MSB first
    wire logic [21:0] ob = {audio_analogue_test_out, telecom_analogue_test_out,
        production_test_select_out, converter_enable_out, external_reference_enable_out,
        reference_bypass_connect_out, converter_sync_enable_out, panel_bias_enable_out,
        position_mode_out, pressure_mode_out, interrupt_mode_out, y_plus_plate_ground_out,
        y_minus_plate_ground_out, x_plus_plate_ground_out, x_minus_plate_ground_out,
        y_plus_plate_power_out, y_minus_plate_power_out, x_plus_plate_power_out,
        x_minus_plate_power_out};
    // Rows: offset, word written, word read back, snapshot
    logic [57:0] rows [11] = '{
        {4'h9,16'hFFFF,16'h0BFF,22'h000CFF}, {4'hA,16'hFF7F,16'h803F,22'h00FCFF},
        {4'hD,16'hFFFF,16'h003F,22'h3FFCFF}, {4'hC,16'hFFFF,16'hAA95,22'h3FFCFF},
        {4'hE,16'h1234,16'h0000,22'h3FFCFF}, {4'hB,16'hFFFF,16'h0000,22'h3FFCFF},
        {4'h9,16'h0215,16'h0215,22'h3FF415}, {4'h9,16'h0100,16'h0100,22'h3FF200},
        {4'h9,16'h0380,16'h0380,22'h3FF480}, {4'h9,16'h0000,16'h0000,22'h3FF100},
        {4'hA,16'h0000,16'h0000,22'h3F0100}};
    // Ideal comparator
    assign comparator_high_in = TGT >= sar_trial_code_out;
    tpac_regs uut (.*);
    tpac_ctrl_model ctl (.mclk_in(mclk_in), .rdata_in(reg_rdata_out),
        .addr_out(reg_addr_in), .wdata_out(reg_wdata_in), .wr_out(reg_write_in),
        .rd_out(reg_read_in), .tpin_out(test_pin_in));
    // Clock
    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end
    // Verdict
    task automatic end_of_test;
        if (failures == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Hang guard
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            end_of_test;
        end
    end
    // Wait for idle; the hang guard bounds it
    task automatic wait_idle;
        repeat (2) @(posedge mclk_in);
        while (conversion_busy_out !== 1'b0) @(posedge mclk_in);
        `CHK(conversion_busy_out, 1'b0)
    endtask
    // Main sequence
    initial begin
        {rst_b_in, sync_trigger_in, x_plus_plate_pin_in, x_minus_plate_pin_in} = 4'h3;
        repeat (2) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        repeat (6) @(posedge mclk_in);
        foreach (rows[i]) begin
            ctl.wr(rows[i][57:54], rows[i][53:38]);
            ctl.rd(rows[i][57:54], rdv);
            `CHK(rdv, rows[i][37:22])
            `CHK(ob, rows[i][21:0])
        end
        for (int i = 0; i < 8; i++) begin
            ctl.wr(4'hA, 16'(i << 2));
            #1 `CHK(input_select_out, 8'(8'h01 << i))
        end
        // Test writes dropped, pin low
        ctl.tpin_out <= 1'b0;
        repeat (5) @(posedge mclk_in);
        ctl.wr(4'hD, 16'h0000);
        ctl.rd(4'hD, rdv);
        `CHK(rdv, 16'h003F)
        ctl.tpin_out <= 1'b1;
        // Pen state, one plate low at a time
        x_plus_plate_pin_in <= 1'b0;
        repeat (6) @(posedge mclk_in);
        ctl.rd(4'h9, rdv);
        `CHK(rdv[13:12], 2'b01)
        {x_plus_plate_pin_in, x_minus_plate_pin_in} <= 2'b10;
        repeat (6) @(posedge mclk_in);
        ctl.rd(4'h9, rdv);
        `CHK(rdv[13:12], 2'b10)
        // Conversion, then start with bit set
        ctl.wr(4'hA, 16'h8000);
        ctl.wr(4'hA, 16'h8080);
        ctl.rd(4'hB, rdv);
        `CHK(rdv[15], 1'b0)
        wait_idle;
        ctl.rd(4'hB, rdv);
        `CHK(rdv, RES)
        ctl.wr(4'hA, 16'h8080);
        ctl.rd(4'hB, rdv);
        `CHK(rdv, RES)
        // Sync mode waits for the trigger; disable aborts it
        ctl.wr(4'hA, 16'h8001);
        ctl.wr(4'hA, 16'h8081);
        repeat (60) @(posedge mclk_in);
        `CHK(conversion_busy_out, 1'b1)
        ctl.wr(4'hA, 16'h0001);
        ctl.rd(4'hB, rdv);
        `CHK(rdv[15], 1'b0)
        ctl.wr(4'hA, 16'h8001);
        ctl.wr(4'hA, 16'h8081);
        sync_trigger_in <= 1'b1;
        wait_idle;
        @(posedge mclk_in);
        sync_trigger_in <= 1'b0;
        ctl.rd(4'hB, rdv);
        `CHK(rdv, RES)
        end_of_test;
    end
endmodule // touch_panel_adc_control_regs_bench
`default_nettype wire
